// ==== design/stop_recovery_watchdog.sv ====
// Purpose: STOP wake-up selection, power-on delay, brownout hold, clock prescaler
//          and RC-timed watchdog of a small microcontroller.
// Assumes: Pins and the supply comparator are asynchronous; CPU strobes share CLK.
// Notes: The RC oscillator is an enable pulse derived from CLK.
// What this block does
// - First register write-only except read-only top bit
// - Warm flag 1 after STOP wake, else 0
// - Bit 0 divides system and timer clocks by 16
// - Divide select cleared on every STOP wake-up
// - First register bits 4:2 pick wake source
// - Bit 6 sets wake level, 0 at power-on
// - Bit 5 low skips delay after wake
// - Output-configured pins drop out of wake equation
// - Second register bits 4:2 pick gate sources
// - Second register bit 6 level; reserved bits zero
// - Either register's wake condition ends STOP
// - Watchdog is retriggerable one-shot resetting device
// - First refresh starts watchdog, later ones restart
// - Watchdog counts on RC oscillator ticks
// - Watchdog mode writable 120 clocks, never read
// - Bits 1:0 choose 5/10/20/80 ms minimum
// - Bit 2 keeps watchdog counting in HALT
// - Bit 3 keeps watchdog counting in STOP
// - Option input starts watchdog after brownout or watchdog timeout; not yet synced when RESET releases
// - Brownout holds reset, recovery runs power-on
// - Delay triggered by supply, delayed wake, watchdog
// - Power-on delay at least 2.5 ms
// - Execution restarts at address 000Ch
`timescale 1ns/1ps
module stop_recovery_watchdog
    import stop_wake_pkg::*;
#(
    parameter int POR_TICKS = POR_TICKS_MIN,
    parameter int WDT_TICKS_0 = WDT_TICKS_MIN_0,
    parameter int WDT_TICKS_1 = WDT_TICKS_MIN_1,
    parameter int WDT_TICKS_2 = WDT_TICKS_MIN_2,
    parameter int WDT_TICKS_3 = WDT_TICKS_MIN_3
)
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic [7:0] P0_IN,
    input wire logic [7:0] P2_IN,
    input wire logic [3:1] P3_IN,
    input wire logic [7:0] P0_DIR_OUT,
    input wire logic [7:0] P2_DIR_OUT,
    input wire logic SUPPLY_LOW,
    input wire logic WDT_AT_POR_OPT,
    input wire logic STOP_REQ,
    input wire logic HALT_ACTIVE,
    input wire logic WDT_CMD,
    output logic RESET_OUT,
    output logic CPU_RUN,
    output logic STOP_ACTIVE,
    output logic SCLK_EN,
    output logic TIMER_CLOCK_EN,
    output logic WDT_RESET,
    output logic [15:0] RESTART_VECTOR
);

    logic [20:0] pin_meta;
    logic [20:0] pin_sync;
    logic [7:0] p0;
    logic [7:0] p2;
    logic [3:1] p3;
    logic supply_low;
    logic wdt_opt;
    stop_wake_control_s stop_wake_control;
    stop_wake_second_s stop_wake_control_second;
    watchdog_mode_s wdm;
    seq_state_e state;
    seq_state_e next_state;
    logic [5:0] rc_div;
    logic rc_tick;
    logic [TICK_W-1:0] por_cnt;
    logic por_done;
    logic [TICK_W-1:0] wdt_cnt;
    logic [TICK_W-1:0] wdt_limit;
    logic wdt_on;
    logic wdt_active;
    logic wdt_timeout;
    logic [6:0] win_cnt;
    logic win_open;
    logic [3:0] prescale;
    logic lvl1;
    logic ok1;
    logic lvl2;
    logic ok2;
    logic wake_hit;
    logic cold;

    // Pins and the comparator are asynchronous; the strap is caught after release
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            pin_meta <= '0;
            pin_sync <= '0;
        end
        else
        begin
            pin_meta <= {WDT_AT_POR_OPT, SUPPLY_LOW, P3_IN, P2_IN, P0_IN};
            pin_sync <= pin_meta;
        end
    end

    assign p0 = pin_sync[7:0];
    assign p2 = pin_sync[15:8];
    assign p3 = pin_sync[18:16];
    assign supply_low = pin_sync[19];
    assign wdt_opt = pin_sync[20];

    // RC oscillator stand-in: one tick every RC_DIV crystal clocks
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            rc_div <= '0;
        else if (rc_div == RC_DIV_LAST)
            rc_div <= '0;
        else
            rc_div <= rc_div + 6'h01;
    end

    assign rc_tick = (rc_div == RC_DIV_LAST);

    // Output-direction pins are forced to the value that leaves the gate unaffected
    always_comb
    begin
        lvl1 = 1'b0;
        ok1 = 1'b1;
        case (stop_wake_control.src)
            SRC_P3_LINE1: lvl1 = p3[1];
            SRC_P3_LINE2: lvl1 = p3[2];
            SRC_P3_LINE3: lvl1 = p3[3];
            SRC_P2_LINE7:
            begin
                lvl1 = p2[7];
                ok1 = !P2_DIR_OUT[7];
            end
            SRC_NOR_P2_LOW: lvl1 = ~|(p2[3:0] & ~P2_DIR_OUT[3:0]);
            SRC_NOR_P2_ALL: lvl1 = ~|(p2 & ~P2_DIR_OUT);
            default: ok1 = 1'b0;
        endcase
    end

    always_comb
    begin
        lvl2 = 1'b0;
        ok2 = 1'b1;
        case (stop_wake_control_second.src)
            SRC2_NAND_P2_LOW: lvl2 = ~&(p2[3:0] | P2_DIR_OUT[3:0]);
            SRC2_NAND_P2_ALL: lvl2 = ~&(p2 | P2_DIR_OUT);
            SRC2_NOR_P3: lvl2 = ~|p3;
            SRC2_NAND_P3: lvl2 = ~&p3;
            SRC2_NOR_P3_P0:
                lvl2 = ~|{p3, p0[0] & ~P0_DIR_OUT[0], p0[7] & ~P0_DIR_OUT[7]};
            SRC2_NAND_P3_P0:
                lvl2 = ~&{p3, p0[0] | P0_DIR_OUT[0], p0[7] | P0_DIR_OUT[7]};
            SRC2_NAND_P3_P2: lvl2 = ~&{p3, p2[2:0] | P2_DIR_OUT[2:0]};
            default: ok2 = 1'b0;
        endcase
    end

    // The polarity bit acts as the XOR stage in front of the wake gate
    assign wake_hit = (ok1 && (lvl1 == stop_wake_control.pol)) || (ok2 && (lvl2 == stop_wake_control_second.pol));

    always_comb
    begin
        case (wdm.sel)
            2'b00: wdt_limit = TICK_W'(WDT_TICKS_0);
            2'b01: wdt_limit = TICK_W'(WDT_TICKS_1);
            2'b10: wdt_limit = TICK_W'(WDT_TICKS_2);
            default: wdt_limit = TICK_W'(WDT_TICKS_3);
        endcase
    end

    assign wdt_active = wdt_on && (((state == ST_RUN) && (!HALT_ACTIVE || wdm.halt_run))
        || ((state == ST_STOP) && wdm.stop_run));
    assign wdt_timeout = wdt_active && rc_tick && !WDT_CMD
        && (wdt_cnt == wdt_limit - TICK_W'(1));
    assign por_done = rc_tick && (por_cnt == TICK_W'(POR_TICKS - 1));
    assign cold = (state == ST_HOLD) || wdt_timeout;

    always_comb
    begin
        next_state = state;
        case (state)
            ST_HOLD: next_state = ST_DELAY;
            ST_DELAY:
                if (por_done)
                    next_state = ST_RUN;
            ST_RUN:
                if (STOP_REQ)
                    next_state = ST_STOP;
            ST_STOP:
                if (wake_hit)
                    next_state = stop_wake_control.delay ? ST_DELAY : ST_RUN;
            default: next_state = ST_HOLD;
        endcase
        if (wdt_timeout)
            next_state = ST_DELAY;
        if (supply_low)
            next_state = ST_HOLD;
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            state <= ST_HOLD;
            por_cnt <= '0;
        end
        else
        begin
            state <= next_state;
            if (next_state != ST_DELAY || state != ST_DELAY)
                por_cnt <= '0;
            else if (rc_tick)
                por_cnt <= por_cnt + TICK_W'(1);
        end
    end

    // Software registers; a cold restart (power-on or watchdog) restores defaults
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            stop_wake_control <= SWC_RESET;
            stop_wake_control_second <= SWS_RESET;
            wdm <= WDM_RESET;
        end
        else if (cold)
        begin
            stop_wake_control <= SWC_RESET;
            stop_wake_control_second <= SWS_RESET;
            wdm <= WDM_RESET;
        end
        else if (state == ST_STOP && wake_hit)
        begin
            stop_wake_control.warm <= 1'b1;
            stop_wake_control.div16 <= 1'b0;
        end
        else if (WR)
        begin
            if (ADDR == STOP_WAKE_CONTROL_ADDR)
                stop_wake_control <= {stop_wake_control.warm, WDATA[6:2], 1'b0, WDATA[0]};
            if (ADDR == STOP_WAKE_CONTROL_SECOND_ADDR)
                stop_wake_control_second <= {1'b0, WDATA[6], 1'b0, WDATA[4:2], 2'b00};
            if (ADDR == WATCHDOG_MODE_ADDR && win_open)
                wdm <= WDATA[3:0];
        end
    end

    // Write window for the watchdog mode opens on each entry into execution
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            win_open <= 1'b0;
            win_cnt <= '0;
        end
        else if (next_state == ST_RUN && state != ST_RUN)
        begin
            win_open <= 1'b1;
            win_cnt <= '0;
        end
        else if (state != ST_RUN)
            win_open <= 1'b0;
        else if (win_open)
        begin
            win_cnt <= win_cnt + 7'h01;
            if (win_cnt == WIN_LAST)
                win_open <= 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            wdt_on <= 1'b0;
            wdt_cnt <= '0;
        end
        else if (state == ST_HOLD || wdt_timeout)
        begin
            wdt_on <= wdt_opt;
            wdt_cnt <= '0;
        end
        else if (WDT_CMD && state == ST_RUN)
        begin
            wdt_on <= 1'b1;
            wdt_cnt <= '0;
        end
        else if (wdt_active && rc_tick)
            wdt_cnt <= wdt_cnt + TICK_W'(1);
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            prescale <= '0;
        else
            prescale <= prescale + 4'h1;
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            RESET_OUT <= 1'b1;
            CPU_RUN <= 1'b0;
            STOP_ACTIVE <= 1'b0;
            SCLK_EN <= 1'b0;
            TIMER_CLOCK_EN <= 1'b0;
            WDT_RESET <= 1'b0;
            RESTART_VECTOR <= RESTART_ADDR;
        end
        else
        begin
            RESET_OUT <= (next_state == ST_HOLD) || (next_state == ST_DELAY);
            CPU_RUN <= (next_state == ST_RUN);
            STOP_ACTIVE <= (next_state == ST_STOP);
            SCLK_EN <= (next_state == ST_RUN) && !HALT_ACTIVE
                && (!stop_wake_control.div16 || prescale == PRESCALE_LAST);
            TIMER_CLOCK_EN <= (next_state == ST_RUN)
                && (!stop_wake_control.div16 || prescale == PRESCALE_LAST);
            WDT_RESET <= wdt_timeout;
            if (next_state == ST_RUN && state != ST_RUN)
                RESTART_VECTOR <= RESTART_ADDR;
        end
    end

    // Only the warm flag reads back; the other registers are write-only
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            RDATA <= 8'h00;
        else if (RD && ADDR == STOP_WAKE_CONTROL_ADDR)
            RDATA <= {stop_wake_control.warm, 7'h00};
        else
            RDATA <= 8'h00;
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);

    smr_readback_a: assert property (RD |=> RDATA[6:0] == 7'h00)
        else $error("write-only bits visible on read");
    warm_on_wake_a: assert property (state == ST_STOP && wake_hit && !supply_low
        && !wdt_timeout |=> stop_wake_control.warm && !stop_wake_control.div16)
        else $error("wake did not set warm or clear divide");
    cold_flag_a: assert property (wdt_timeout |=> !stop_wake_control.warm && RESET_OUT)
        else $error("warm flag survived watchdog reset");
    fast_wake_a: assert property (state == ST_STOP && wake_hit && !stop_wake_control.delay
        && !supply_low && !wdt_timeout |=> state == ST_RUN && CPU_RUN)
        else $error("fast wake did not resume at once");
    delay_wake_a: assert property (state == ST_STOP && wake_hit && stop_wake_control.delay
        && !supply_low |=> state == ST_DELAY && RESET_OUT)
        else $error("delayed wake skipped power-on delay");
    brownout_hold_a: assert property (supply_low |=> state == ST_HOLD && RESET_OUT
        && !CPU_RUN)
        else $error("brownout did not hold reset");
    wdt_lock_a: assert property (!win_open && WR && ADDR == WATCHDOG_MODE_ADDR && !cold
        |=> $stable(wdm))
        else $error("watchdog mode changed after lock");
    prescale_gap_a: assert property (stop_wake_control.div16 && SCLK_EN && !WR |=> !SCLK_EN)
        else $error("divided clock enable too frequent");
    wdt_restart_a: assert property (WDT_CMD && state == ST_RUN && !wdt_timeout
        && !supply_low |=> wdt_on && wdt_cnt == '0)
        else $error("watchdog not restarted");
    delay_length_a: assert property ($rose(state == ST_DELAY) |-> por_cnt == '0
        ##1 !CPU_RUN[*8])
        else $error("power-on delay ended early");

    wake_fast_c: cover property (state == ST_STOP ##1 state == ST_RUN);
    wake_delay_c: cover property (state == ST_STOP ##1 state == ST_DELAY);
    wdt_fire_c: cover property (WDT_RESET);
    brownout_c: cover property (state == ST_RUN ##1 state == ST_HOLD);

endmodule : stop_recovery_watchdog

// ==== design/stop_wake_pkg.sv ====
// Purpose: Shared constants and types for the STOP wake-up and watchdog block.
// Assumes: 40 MHz crystal clock; the RC oscillator is modelled as a 1 MHz tick.
// Notes: Register offsets are byte addresses on the plain register port.
package stop_wake_pkg;

    localparam logic [7:0] STOP_WAKE_CONTROL_ADDR = 8'h0B;
    localparam logic [7:0] STOP_WAKE_CONTROL_SECOND_ADDR = 8'h0D;
    localparam logic [7:0] WATCHDOG_MODE_ADDR = 8'h0F;

    typedef struct packed {
        logic warm;
        logic pol;
        logic delay;
        logic [2:0] src;
        logic rsv;
        logic div16;
    } stop_wake_control_s;

    typedef struct packed {
        logic rsv7;
        logic pol;
        logic rsv5;
        logic [2:0] src;
        logic [1:0] rsv;
    } stop_wake_second_s;

    typedef struct packed {
        logic stop_run;
        logic halt_run;
        logic [1:0] sel;
    } watchdog_mode_s;

    localparam stop_wake_control_s SWC_RESET = 8'h20;
    localparam stop_wake_second_s SWS_RESET = 8'h00;
    localparam watchdog_mode_s WDM_RESET = 4'hC;

    // First register wake sources
    localparam logic [2:0] SRC_RESET_ONLY = 3'h0;
    localparam logic [2:0] SRC_P3_LINE1 = 3'h2;
    localparam logic [2:0] SRC_P3_LINE2 = 3'h3;
    localparam logic [2:0] SRC_P3_LINE3 = 3'h4;
    localparam logic [2:0] SRC_P2_LINE7 = 3'h5;
    localparam logic [2:0] SRC_NOR_P2_LOW = 3'h6;
    localparam logic [2:0] SRC_NOR_P2_ALL = 3'h7;
    // Second register wake sources
    localparam logic [2:0] SRC2_NAND_P2_LOW = 3'h1;
    localparam logic [2:0] SRC2_NAND_P2_ALL = 3'h2;
    localparam logic [2:0] SRC2_NOR_P3 = 3'h3;
    localparam logic [2:0] SRC2_NAND_P3 = 3'h4;
    localparam logic [2:0] SRC2_NOR_P3_P0 = 3'h5;
    localparam logic [2:0] SRC2_NAND_P3_P0 = 3'h6;
    localparam logic [2:0] SRC2_NAND_P3_P2 = 3'h7;

    typedef enum logic [1:0] {
        ST_HOLD = 2'b00,
        ST_DELAY = 2'b01,
        ST_RUN = 2'b10,
        ST_STOP = 2'b11
    } seq_state_e;

    localparam int CLK_PERIOD_PS = 25000;
    localparam int RC_PERIOD_PS = 1000000;
    localparam int RC_DIV = RC_PERIOD_PS / CLK_PERIOD_PS;
    localparam logic [5:0] RC_DIV_LAST = 6'(RC_DIV - 1);
    localparam int RC_PERIOD_NS = RC_PERIOD_PS / 1000;

    localparam int POR_DELAY_NS = 2500000;
    localparam int POR_TICKS_MIN = (POR_DELAY_NS + RC_PERIOD_NS - 1) / RC_PERIOD_NS;
    localparam int WDT_MIN_MS_0 = 5;
    localparam int WDT_MIN_MS_1 = 10;
    localparam int WDT_MIN_MS_2 = 20;
    localparam int WDT_MIN_MS_3 = 80;
    localparam int NS_PER_MS = 1000000;
    localparam int WDT_TICKS_MIN_0 = (WDT_MIN_MS_0 * NS_PER_MS + RC_PERIOD_NS - 1) / RC_PERIOD_NS;
    localparam int WDT_TICKS_MIN_1 = (WDT_MIN_MS_1 * NS_PER_MS + RC_PERIOD_NS - 1) / RC_PERIOD_NS;
    localparam int WDT_TICKS_MIN_2 = (WDT_MIN_MS_2 * NS_PER_MS + RC_PERIOD_NS - 1) / RC_PERIOD_NS;
    localparam int WDT_TICKS_MIN_3 = (WDT_MIN_MS_3 * NS_PER_MS + RC_PERIOD_NS - 1) / RC_PERIOD_NS;

    localparam int TICK_W = 17;
    localparam int WIN_XTAL_CYCLES = 120;
    localparam logic [6:0] WIN_LAST = 7'(WIN_XTAL_CYCLES - 1);
    localparam logic [3:0] PRESCALE_LAST = 4'hF;
    localparam logic [15:0] RESTART_ADDR = 16'h000C;

endpackage : stop_wake_pkg

// ==== verif/wake_pin_model.sv ====
// Purpose: Port pin side of the wake logic, holding idle levels and timed wake pulses.
// Assumes: Port pull-ups are enabled, so a released line goes back high.
// Notes: A pulse is held for whole clocks before the line is released.
`timescale 1ns/1ps
module wake_pin_model
(
    input wire logic CLK,
    output logic [7:0] P0_IN,
    output logic [7:0] P2_IN,
    output logic [3:1] P3_IN
);
    initial
    begin
        P0_IN = 8'hFF;
        P2_IN = 8'hFF;
        P3_IN = 3'h7;
    end

    // Port 0, 2 or 3 line b held low for n clocks
    task automatic hold_low(input int p, input int b, input int n);
        @(posedge CLK);
        case (p)
            0: P0_IN[b] <= 1'b0;
            2: P2_IN[b] <= 1'b0;
            default: P3_IN[b] <= 1'b1 ^ 1'b1;
        endcase
        repeat (n) @(posedge CLK);
        P0_IN <= 8'hFF;
        P2_IN <= 8'hFF;
        P3_IN <= 3'h7;
    endtask : hold_low
endmodule : wake_pin_model

// ==== verif/stop_recovery_watchdog_tb_top.sv ====
// Purpose: Self-checking bench for STOP wake-up, power-on delay, brownout and watchdog.
// Assumes: Short RC counts (4 delay ticks, 6/8/10/12 watchdog ticks), tick every 40 CLK.
// Notes: Cycle windows allow one RC tick of phase slack plus pin sync.
`timescale 1ns/1ps
module stop_recovery_watchdog_tb_top
    import stop_wake_pkg::*;
;
    localparam int POR_T = 4;
    localparam int RCD = 40;
    logic CLK = 1'b0;
    logic RESET = 1'b1;
    logic [7:0] ADDR = 8'h00;
    logic [7:0] WDATA = 8'h00;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [7:0] RDATA;
    logic [7:0] P0_IN;
    logic [7:0] P2_IN;
    logic [3:1] P3_IN;
    logic [7:0] P0_DIR_OUT = 8'h00;
    logic [7:0] P2_DIR_OUT = 8'h00;
    logic HALT_ACTIVE = 1'b0;
    logic SUPPLY_LOW = 1'b0;
    logic STOP_REQ = 1'b0;
    logic WDT_CMD = 1'b0;
    logic RESET_OUT;
    logic CPU_RUN;
    logic STOP_ACTIVE;
    logic SCLK_EN;
    logic TIMER_CLOCK_EN;
    logic WDT_RESET;
    logic [15:0] RESTART_VECTOR;
    logic [7:0] rv;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    int n;
    int ns;
    int nt;

    always #12.5 CLK = ~CLK;

    wake_pin_model i_wake_pin_model (.CLK(CLK), .P0_IN(P0_IN), .P2_IN(P2_IN), .P3_IN(P3_IN));

    stop_recovery_watchdog #(.POR_TICKS(POR_T), .WDT_TICKS_0(6), .WDT_TICKS_1(8),
        .WDT_TICKS_2(10), .WDT_TICKS_3(12)) i_stop_recovery_watchdog (
        .CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .P0_IN(P0_IN), .P2_IN(P2_IN), .P3_IN(P3_IN),
        .P0_DIR_OUT(P0_DIR_OUT), .P2_DIR_OUT(P2_DIR_OUT), .SUPPLY_LOW(SUPPLY_LOW),
        .WDT_AT_POR_OPT(1'b0), .STOP_REQ(STOP_REQ), .HALT_ACTIVE(HALT_ACTIVE),
        .WDT_CMD(WDT_CMD), .RESET_OUT(RESET_OUT), .CPU_RUN(CPU_RUN),
        .STOP_ACTIVE(STOP_ACTIVE), .SCLK_EN(SCLK_EN), .TIMER_CLOCK_EN(TIMER_CLOCK_EN),
        .WDT_RESET(WDT_RESET), .RESTART_VECTOR(RESTART_VECTOR));

    task automatic end_sim();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    // The whole sequence needs about 2000 cycles
    always @(posedge CLK)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            end_sim();
        end
    end

    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val

    task automatic check_rng(input int got, input int lo, input int hi);
        tests_run++;
        if (got < lo || got > hi)
        begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : check_rng

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge CLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        d = RDATA;
    endtask : rd

    // 0 pulses STOP_REQ, 1 pulses WDT_CMD
    task automatic pulse(input int which);
        @(posedge CLK);
        if (which == 0)
            STOP_REQ <= 1'b1;
        else
            WDT_CMD <= 1'b1;
        @(posedge CLK);
        STOP_REQ <= 1'b0;
        WDT_CMD <= 1'b0;
    endtask : pulse

    task automatic wait_run(output int k);
        k = 0;
        // Called right at an edge, the old run level would still be visible
        #1;
        while (CPU_RUN !== 1'b1 && k < 1000)
        begin
            @(posedge CLK);
            #1;
            k++;
        end
    endtask : wait_run

    task automatic wdt_time(output int k);
        pulse(1);
        k = 0;
        while (WDT_RESET !== 1'b1 && k < 2000)
        begin
            @(posedge CLK);
            #1;
            k++;
        end
    endtask : wdt_time

    task automatic count_en(input int len, output int s, output int t);
        s = 0;
        t = 0;
        repeat (len)
        begin
            @(posedge CLK);
            #1;
            s += (SCLK_EN === 1'b1);
            t += (TIMER_CLOCK_EN === 1'b1);
        end
    endtask : count_en

    initial
    begin
        repeat (3) @(posedge CLK);
        #1;
        check_val(RESTART_VECTOR, 16'h000C);
        check_val(16'(RESET_OUT), 16'h0001);
        RESET <= 1'b0;
        wait_run(n);
        check_rng(n, (POR_T - 1) * RCD, POR_T * RCD + RCD + 10);
        rd(STOP_WAKE_CONTROL_ADDR, rv);
        check_val(16'(rv), 16'h0000);
        rd(STOP_WAKE_CONTROL_SECOND_ADDR, rv);
        check_val(16'(rv), 16'h0000);
        rd(WATCHDOG_MODE_ADDR, rv);
        check_val(16'(rv), 16'h0000);
        rd(8'h33, rv);
        check_val(16'(rv), 16'h0000);
        $display("test cold_regs done");

        wr(STOP_WAKE_CONTROL_ADDR, 8'h21);
        count_en(64, ns, nt);
        check_rng(ns, 4, 4);
        check_rng(nt, 4, 4);
        // Fast wake on port 3 line 1 low, divide still on when STOP starts
        wr(STOP_WAKE_CONTROL_ADDR, 8'h09);
        pulse(0);
        repeat (3) @(posedge CLK);
        #1;
        check_val(16'(STOP_ACTIVE), 16'h0001);
        fork
            i_wake_pin_model.hold_low(3, 1, 12);
            wait_run(n);
        join
        check_rng(n, 2, 14);
        count_en(16, ns, nt);
        check_rng(ns, 16, 16);
        check_rng(nt, 16, 16);
        HALT_ACTIVE <= 1'b1;
        count_en(16, ns, nt);
        HALT_ACTIVE <= 1'b0;
        check_rng(ns, 0, 0);
        check_rng(nt, 16, 16);
        rd(STOP_WAKE_CONTROL_ADDR, rv);
        check_val(16'(rv), 16'h0080);
        // High polarity with idle-high pin wakes at once
        wr(STOP_WAKE_CONTROL_ADDR, 8'h48);
        pulse(0);
        wait_run(n);
        check_rng(n, 1, 10);
        $display("test fast_wake done");

        wr(STOP_WAKE_CONTROL_ADDR, 8'h20);
        wr(STOP_WAKE_CONTROL_SECOND_ADDR, 8'h44);
        @(posedge CLK);
        P2_DIR_OUT <= 8'h01;
        pulse(0);
        i_wake_pin_model.hold_low(2, 0, 12);
        repeat (4) @(posedge CLK);
        #1;
        check_val(16'(STOP_ACTIVE), 16'h0001);
        fork
            i_wake_pin_model.hold_low(2, 1, 12);
            wait_run(n);
        join
        check_rng(n, (POR_T - 1) * RCD, POR_T * RCD + RCD + 14);
        P2_DIR_OUT <= 8'h00;
        // Port 0 line 0 as an output is masked, line 7 still wakes
        wr(STOP_WAKE_CONTROL_SECOND_ADDR, 8'h58);
        P0_DIR_OUT <= 8'h01;
        pulse(0);
        i_wake_pin_model.hold_low(0, 0, 12);
        #1;
        check_val(16'(STOP_ACTIVE), 16'h0001);
        fork
            i_wake_pin_model.hold_low(0, 7, 12);
            wait_run(n);
        join
        check_rng(n, (POR_T - 1) * RCD, POR_T * RCD + RCD + 14);
        P0_DIR_OUT <= 8'h00;
        $display("test delayed_wake done");

        @(posedge CLK);
        SUPPLY_LOW <= 1'b1;
        repeat (50) @(posedge CLK);
        #1;
        check_val({14'h0, RESET_OUT, CPU_RUN}, 16'h0002);
        SUPPLY_LOW <= 1'b0;
        wait_run(n);
        check_rng(n, (POR_T - 1) * RCD, POR_T * RCD + RCD + 10);
        $display("test brownout done");

        // Inside the write window: 10 ms select, refresh restarts the count
        wr(WATCHDOG_MODE_ADDR, 8'h0D);
        pulse(1);
        repeat (150) @(posedge CLK);
        wdt_time(n);
        check_rng(n, 7 * RCD - 2, 8 * RCD + 10);
        @(posedge CLK);
        #1;
        check_val(16'(RESET_OUT), 16'h0001);
        wait_run(n);
        check_rng(n, (POR_T - 1) * RCD - 2, POR_T * RCD + RCD + 10);
        rd(STOP_WAKE_CONTROL_ADDR, rv);
        check_val(16'(rv), 16'h0000);
        // Late write is locked out, so the 5 ms default stays
        repeat (130) @(posedge CLK);
        wr(WATCHDOG_MODE_ADDR, 8'h0F);
        wdt_time(n);
        check_rng(n, 5 * RCD - 2, 6 * RCD + 10);
        wait_run(n);
        $display("test watchdog done");
        end_sim();
    end
endmodule : stop_recovery_watchdog_tb_top
